// [rtl/cbp_pkg.sv]
// Constants, types and rule summary for the byte-wide host port
// Rules for this block, the host and the board
// RL1: Host gives an eleven-bit byte address, top line most significant, high is one.
// RL2: Eight-bit two-way data bus; device drives on reads, host on writes.
// RL3: A group transfers only while its active-low select is low.
// RL4: Host never pulls two group selects low during one read.
// RL5: Strobe style: read lead low is the read strobe for the group.
// RL6: Strobe style: write lead low stores the data byte at the address.
// RL7: Direction style: direction lead high means read, low means write.
// RL8: Direction style: internal select is group select OR auxiliary select.
// RL9: Unused auxiliary select is tied low on the board.
// RL10: Strobe style: acknowledge high when transfer can complete, low while not.
// RL11: Strobe style: host waits while the acknowledge stays low.
// RL12: Direction style read: acknowledge goes low only once data is valid.
// RL13: Direction style write: acknowledge low confirms data taken; three-state output.
// RL14: Interrupt output is high-active when polarity strap high, else low-active.
// RL15: Board sets polarity strap to suit the processor.
// RL16: Bus-style strap low picks strobe style, high picks direction style.
// RL17: Data bus driven only during a selected read, released otherwise.
// RL18: Acknowledge released whenever its group is not selected.
package cbp_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int GROUPS = 4;
	localparam int WORDS = 2048;
	// Final wait count; acknowledge follows ACK_DLY+2 cycles after a seen strobe (memory access latency)
	localparam logic [1:0] ACK_DLY = 2'h2;
	localparam logic [1:0] CNT_RST = 2'h0;
	localparam logic [DATA_W-1:0] MEM_RST = 8'h00;

	typedef enum logic [1:0] {CBP_IDLE, CBP_WAIT, CBP_DONE} cbp_state_e;

	// Synchronised host pins
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [GROUPS-1:0] sel_n;
		logic              rd_lead;
		logic              wr_lead;
		logic              style;
		logic              pol;
	} cbp_pins_s;
endpackage

// [rtl/cbp_group_mem.sv]
// One group's byte storage, addressed by index
`timescale 1ns/1ps
`default_nettype none
module cbp_group_mem (
	input  wire logic                      ref_clk_i, // Core clock
	input  wire logic                      rstn_i,    // Async reset, active low
	input  wire logic                      we_i,      // Write pulse
	input  wire logic [cbp_pkg::ADDR_W-1:0] addr_i,   // Byte address
	input  wire logic [cbp_pkg::DATA_W-1:0] wdata_i,  // Write byte
	output logic      [cbp_pkg::DATA_W-1:0] rdata_o   // Read byte, registered
);
	logic [cbp_pkg::DATA_W-1:0] mem [cbp_pkg::WORDS];

	// Storage array, cleared at reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < cbp_pkg::WORDS; i++) begin
				mem[i] <= cbp_pkg::MEM_RST;
			end
		end else if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// Registered read
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= cbp_pkg::MEM_RST;
		end else begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule
`default_nettype wire

// [rtl/cbp_host_port.sv]
// Asynchronous byte-wide host port with four groups
`timescale 1ns/1ps
`default_nettype none
module cbp_host_port (
	input  wire logic                              ref_clk_i,              // Core clock 250 MHz
	input  wire logic                              rstn_i,                 // Async reset, active low
	input  wire logic [cbp_pkg::ADDR_W-1:0]         addr_i,                 // Host address pins
	input  wire logic [cbp_pkg::DATA_W-1:0]         data_i,                 // Data pins in
	output logic      [cbp_pkg::DATA_W-1:0]         data_o,                 // Data pins out
	output logic                                   data_oe_o,              // Data pins drive enable
	input  wire logic [cbp_pkg::GROUPS-1:0]         group_chip_enable_n_i,  // Group selects
	input  wire logic                              read_dir_i,             // Read or direction lead
	input  wire logic                              store_strobe_or_aux_select_i, // Write or aux select
	output logic      [cbp_pkg::GROUPS-1:0]         transfer_ack_o,         // Acknowledge out
	output logic      [cbp_pkg::GROUPS-1:0]         transfer_ack_oe_o,      // Acknowledge enables
	input  wire logic [cbp_pkg::GROUPS-1:0]         irq_req_i,              // Internal service requests
	output logic      [cbp_pkg::GROUPS-1:0]         group_irq_out_o,        // Interrupt pins
	input  wire logic                              irq_polarity_strap_i,   // Interrupt polarity strap
	input  wire logic                              bus_style_strap_i       // Bus style strap
);
	localparam int G = cbp_pkg::GROUPS;

	cbp_pkg::cbp_pins_s pin_meta;
	cbp_pkg::cbp_pins_s pin;
	cbp_pkg::cbp_state_e state;
	logic [1:0]  cnt;
	logic [G-1:0] act;
	logic [G-1:0] sel_eff;
	logic         is_rd;
	logic         is_wr;
	logic         cyc;
	logic [G-1:0] we;
	logic [cbp_pkg::DATA_W-1:0] rdata [G];
	logic [G-1:0] irq_s1;
	logic [G-1:0] irq_s2;

	// Internal select per group for the current style [RL3] [RL8] [RL9]
	function automatic logic [G-1:0] eff_sel(input cbp_pkg::cbp_pins_s p);
		logic [G-1:0] r;
		r = '0;
		for (int i = 0; i < G; i++) begin
			if (p.style) begin
				r[i] = !(p.sel_n[i] | p.wr_lead);
			end else begin
				r[i] = !p.sel_n[i];
			end
		end
		return r;
	endfunction

	// Two-flop synchroniser of all host pins
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_meta <= '{sel_n: '1, rd_lead: 1'b1, wr_lead: 1'b1, default: '0};
			pin      <= '{sel_n: '1, rd_lead: 1'b1, wr_lead: 1'b1, default: '0};
		end else begin
			pin_meta <= '{addr: addr_i, data: data_i, sel_n: group_chip_enable_n_i,
				rd_lead: read_dir_i, wr_lead: store_strobe_or_aux_select_i,
				style: bus_style_strap_i, pol: irq_polarity_strap_i};
			pin      <= pin_meta;
		end
	end

	// Decode of the shared leads by style [RL16] [RL5] [RL6] [RL7]
	always_comb begin
		sel_eff = eff_sel(pin);
		if (pin.style) begin
			is_rd = pin.rd_lead;
			is_wr = !pin.rd_lead;
		end else begin
			is_rd = !pin.rd_lead;
			is_wr = !pin.wr_lead;
		end
		cyc = (|sel_eff) && (is_rd || is_wr);
	end

	// Access sequencer: wait for latency, then hold done until cycle ends
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= cbp_pkg::CBP_IDLE;
			cnt   <= cbp_pkg::CNT_RST;
			act   <= '0;
		end else begin
			unique case (state)
				cbp_pkg::CBP_IDLE: begin
					if (cyc) begin
						state <= cbp_pkg::CBP_WAIT;
						cnt   <= cbp_pkg::CNT_RST;
						act   <= sel_eff;
					end
				end
				cbp_pkg::CBP_WAIT: begin
					if (!cyc) begin
						state <= cbp_pkg::CBP_IDLE;
						act   <= '0;
					end else if (cnt == cbp_pkg::ACK_DLY) begin
						state <= cbp_pkg::CBP_DONE;
					end else begin
						cnt <= cnt + 2'h1;
					end
				end
				cbp_pkg::CBP_DONE: begin
					if (!cyc) begin
						state <= cbp_pkg::CBP_IDLE;
						act   <= '0;
					end
				end
				default: begin
					state <= cbp_pkg::CBP_IDLE;
				end
			endcase
		end
	end

	// One write pulse per cycle at the end of the latency [RL6] [RL3]
	always_comb begin
		we = '0;
		if (state == cbp_pkg::CBP_WAIT && cyc && cnt == cbp_pkg::ACK_DLY && is_wr) begin
			we = act & sel_eff;
		end
	end

	// Per-group storage
	genvar gi;
	generate
		for (gi = 0; gi < G; gi++) begin : g_mem
			cbp_group_mem u_mem (
				.ref_clk_i (ref_clk_i),
				.rstn_i    (rstn_i),
				.we_i      (we[gi]),
				.addr_i    (pin.addr),
				.wdata_i   (pin.data),
				.rdata_o   (rdata[gi])
			);
		end
	endgenerate

	// Data bus drive only during a selected read [RL17] [RL2] [RL1]
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_o    <= cbp_pkg::MEM_RST;
			data_oe_o <= 1'b0;
		end else begin
			data_oe_o <= cyc && is_rd && state != cbp_pkg::CBP_IDLE;
			data_o    <= cbp_pkg::MEM_RST;
			for (int i = 0; i < G; i++) begin
				if (act[i]) begin
					data_o <= rdata[i];
				end
			end
		end
	end

	// Acknowledge per group: ready level or transfer-acknowledge low
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			transfer_ack_o    <= '1;
			transfer_ack_oe_o <= '0;
		end else begin
			for (int i = 0; i < G; i++) begin
				transfer_ack_oe_o[i] <= cyc && sel_eff[i]; // [RL18] [RL13]
				if (pin.style) begin
					// Low only after data valid or write taken [RL12] [RL13]
					transfer_ack_o[i] <= !(act[i] && state == cbp_pkg::CBP_DONE);
				end else begin
					// Wait low from the first selected edge, high once done [RL10] [RL11]
					transfer_ack_o[i] <= !(cyc && sel_eff[i] && state != cbp_pkg::CBP_DONE);
				end
			end
		end
	end

	// Interrupt pins with strap polarity
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_s1          <= '0;
			irq_s2          <= '0;
			group_irq_out_o <= '0;
		end else begin
			irq_s1          <= irq_req_i;
			irq_s2          <= irq_s1;
			group_irq_out_o <= pin.pol ? irq_s2 : ~irq_s2; // [RL14] [RL15]
		end
	end

	// Data drive implies exactly one group active [RL4] [RL17]
	property p_one_reader;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		data_oe_o |-> $onehot(act);
	endproperty
	a_one_reader: assert property (p_one_reader) else $error("Data driven without one group"); // [RL17]

	// No drive on a write cycle [RL17]
	property p_no_drive_write;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(cyc && is_wr) |=> !data_oe_o;
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("Data driven on write"); // [RL17]

	// Acknowledge released when not selected [RL18]
	property p_ack_release;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		!cyc |=> transfer_ack_oe_o == '0;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("Ack driven while idle"); // [RL18]

	// Strobe style: wait-low held for the first two cycles the sequencer waits [RL10]
	sequence s_wait_begin;
		state == cbp_pkg::CBP_IDLE && cyc && !pin.style;
	endsequence
	property p_ready_wait;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_wait_begin |=> ((transfer_ack_o & act) == '0) [*2];
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("Ready high too early"); // [RL10]

	// Direction style: ack low comes only in done state [RL12]
	property p_dtack_late;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(pin.style && $past(state) != cbp_pkg::CBP_DONE) |-> (&transfer_ack_o);
	endproperty
	a_dtack_late: assert property (p_dtack_late) else $error("Ack low before data"); // [RL12]

	// No second write pulse in the cycle after a write pulse [RL6]
	property p_write_once;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(|we) |=> we == '0;
	endproperty
	a_write_once: assert property (p_write_once) else $error("Double write pulse"); // [RL6]

	// Writes hit only a selected group [RL3]
	property p_write_sel;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(|we) |-> ((we & ~sel_eff) == '0);
	endproperty
	a_write_sel: assert property (p_write_sel) else $error("Write to unselected group"); // [RL3]

	// Interrupt polarity follows strap [RL14]
	property p_irq_pol;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		$stable(pin.pol) |=> group_irq_out_o == ($past(pin.pol) ? $past(irq_s2) : ~$past(irq_s2));
	endproperty
	a_irq_pol: assert property (p_irq_pol) else $error("Interrupt polarity wrong"); // [RL14]

	// Strobe style: ready high in the cycle after the sequencer is done [RL10]
	property p_ready_done;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(state == cbp_pkg::CBP_DONE && cyc && !pin.style) |=> ((transfer_ack_o & act) == act);
	endproperty
	a_ready_done: assert property (p_ready_done) else $error("Ready low after done"); // [RL10]

	// Direction style read: data driven whenever the acknowledge goes low [RL12]
	property p_dtack_data;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(pin.style && is_rd && cyc && state == cbp_pkg::CBP_DONE) |=> data_oe_o;
	endproperty
	a_dtack_data: assert property (p_dtack_data) else $error("Ack low without data"); // [RL12]
endmodule
`default_nettype wire

// [verification/cbp_host_model.sv]
// Behavioural host processor that runs byte cycles on the port
`timescale 1ns/1ps
`default_nettype none
module cbp_host_model (
	input  wire logic        ref_clk_i,     // Core clock
	input  wire logic [7:0]  dev_data_i,    // Device data out
	input  wire logic        dev_data_oe_i, // Device drive enable
	input  wire logic [3:0]  ack_i,         // Acknowledge levels
	input  wire logic [3:0]  ack_oe_i,      // Acknowledge enables
	output logic      [10:0] addr_o,        // Address pins
	output logic      [7:0]  data_o,        // Data bus level
	output logic      [3:0]  sel_n_o,       // Group selects
	output logic             rd_o,          // Read or direction lead
	output logic             wr_o           // Write or aux select lead
);
	logic       drive = 1'b0;
	logic       aux   = 1'b0;
	logic [7:0] dq    = 8'h00;
	// Bus shows the device while it drives, else the host byte or its inverse
	assign data_o = dev_data_oe_i ? dev_data_i : dq;
	// Idle pin levels
	initial begin
		addr_o  = 11'h000;
		sel_n_o = 4'hF;
		rd_o    = 1'b1;
		wr_o    = 1'b1;
	end
	// One cycle; entered just after an edge, returns just after an edge
	task automatic xfer(input logic dir, input logic is_rd, input int g, input logic [10:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output logic ok);
		int n;
		n = 0;
		addr_o = a;
		dq = wd;
		drive = !is_rd;
		sel_n_o[g] = 1'b0;
		if (dir) begin
			rd_o = is_rd;
			wr_o = aux;
		end else if (is_rd) begin
			rd_o = 1'b0;
		end else begin
			wr_o = 1'b0;
		end
		// Hold the cycle until the group answers, bounded
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (!(ack_oe_i[g] && ack_i[g] === !dir) && n < 40);
		rd = data_o;
		ok = (n < 40);
		#1;
		sel_n_o = 4'hF;
		rd_o = 1'b1;
		wr_o = dir ? aux : 1'b1;
		drive = 1'b0;
		dq = ~dq; // Released line no longer shows the last byte
		repeat (5) @(posedge ref_clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// [verification/tb_cpu_bus_port.sv]
// Self-checking bench for the byte-wide host port
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_port;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        style     = 1'b0;
	logic        pol       = 1'b1;
	logic [3:0]  irq_req   = 4'h0;
	logic [10:0] addr;
	logic [7:0]  bus, data_o;
	logic        data_oe, rd_l, wr_l;
	logic [3:0]  sel_n, ack, ack_oe, irq_out;
	int          bad_count = 0;
	int          check_count = 0;
	int          wr_oe_seen = 0;
	// Core clock
	always #2 ref_clk_i = ~ref_clk_i;
	cbp_host_port cbp_host_port_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr),
		.data_i(bus), .data_o(data_o), .data_oe_o(data_oe), .group_chip_enable_n_i(sel_n),
		.read_dir_i(rd_l), .store_strobe_or_aux_select_i(wr_l), .transfer_ack_o(ack),
		.transfer_ack_oe_o(ack_oe), .irq_req_i(irq_req), .group_irq_out_o(irq_out),
		.irq_polarity_strap_i(pol), .bus_style_strap_i(style));
	cbp_host_model cbp_host_model_i (.ref_clk_i(ref_clk_i), .dev_data_i(data_o),
		.dev_data_oe_i(data_oe), .ack_i(ack), .ack_oe_i(ack_oe), .addr_o(addr), .data_o(bus),
		.sel_n_o(sel_n), .rd_o(rd_l), .wr_o(wr_l));
	// Device must not drive while the host drives a write
	always @(posedge ref_clk_i) begin
		if (cbp_host_model_i.drive === 1'b1 && data_oe === 1'b1) wr_oe_seen++;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Strobe style write then read at the top address
	task automatic t_strobe;
		logic [7:0] r;
		logic       ok;
		cbp_host_model_i.xfer(1'b0, 1'b0, 0, 11'h7FF, 8'h5A, r, ok);
		chk(ok, 1'b1);
		cbp_host_model_i.xfer(1'b0, 1'b1, 0, 11'h7FF, 8'h00, r, ok);
		chk(r, 8'h5A);
		chk({data_oe, ack_oe}, 5'h00);
	endtask
	// Same address in every group keeps its own byte
	task automatic t_groups;
		logic [7:0] r;
		logic       ok;
		for (int g = 0; g < 4; g++) cbp_host_model_i.xfer(1'b0, 1'b0, g, 11'h2A5, 8'hC0 + 8'(g), r, ok);
		for (int g = 0; g < 4; g++) begin
			cbp_host_model_i.xfer(1'b0, 1'b1, g, 11'h2A5, 8'h00, r, ok);
			chk(r, 8'hC0 + 8'(g));
		end
	endtask
	// Direction style, with the auxiliary select blocking one cycle
	task automatic t_dir;
		logic [7:0] r;
		logic       ok;
		style = 1'b1;
		tick(4);
		cbp_host_model_i.xfer(1'b1, 1'b0, 2, 11'h000, 8'hA5, r, ok);
		chk(ok, 1'b1);
		cbp_host_model_i.xfer(1'b1, 1'b1, 2, 11'h000, 8'h00, r, ok);
		chk(r, 8'hA5);
		cbp_host_model_i.aux = 1'b1;
		cbp_host_model_i.xfer(1'b1, 1'b0, 2, 11'h000, 8'h3C, r, ok);
		chk(ok, 1'b0);
		cbp_host_model_i.aux = 1'b0;
		cbp_host_model_i.xfer(1'b1, 1'b1, 2, 11'h000, 8'h00, r, ok);
		chk(r, 8'hA5);
		style = 1'b0;
		tick(4);
	endtask
	// Interrupt pins follow requests in both polarities
	task automatic t_irq;
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			for (int k = 0; k < 4; k++) begin
				irq_req = 4'(k * 5);
				tick(6);
				chk({4'h0, irq_out}, {4'h0, (pol ? irq_req : ~irq_req)});
			end
		end
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1;
		rstn_i = 1'b1;
		tick(2);
		t_strobe();
		t_groups();
		t_dir();
		t_irq();
		chk(8'(wr_oe_seen), 8'h00);
		wrap_up();
	end
	// Watchdog well beyond the expected run
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
